// File: logic/display_hw_reset_sequencer.sv
// Hardware reset sequencer: spike filter, blanking, settings reload
`timescale 1ns/1ps
`include "reset_seq_params.svh"
module display_hw_reset_sequencer
#(
    parameter int unsigned RELOAD_CYCLES = `RELOAD_CYCLES,
    parameter int unsigned BLANK_CYCLES  = `BLANK_CYCLES
)
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   hw_reset_n,
    input  wire logic                   sleep_state,
    input  wire logic [31:0]            nvm_word,
    output logic [2:0]                  nvm_addr,
    output logic                        in_reset,
    output logic                        display_blank,
    output logic                        ready,
    output reset_seq_pkg::settings_t    settings
);
    // ------------------------------------------------------------
    // Pin synchroniser and filter
    // ------------------------------------------------------------
    logic        pin_meta;     // First stage, read only by pin_sync
    logic        pin_sync;     // Synchronised pin level
    logic [15:0] low_count;    // Length of the current low level
    logic        reset_seen;   // Filtered reset request
    logic [15:0] high_count;   // Length of the current high level
    logic        was_awake;    // Captured sleep state at reset entry
    logic [31:0] timer;        // Phase timer
    logic [2:0]  word_index;   // Reload word pointer
    reset_seq_pkg::seq_state_t state;
    logic [31:0] blank_count;  // Blanking time since reset was taken
    logic        blank_done;   // Blanking sequence has run its course
    logic        take_reset;   // Filtered reset enters or restarts held

    localparam logic [15:0] ACCEPT = 16'(`ACCEPT_CYCLES);
    localparam logic [2:0]  LAST_WORD = 3'(`NVM_WORDS - 1);

    // Two flops before any logic looks at the pin
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            pin_meta <= hw_reset_n;
            pin_sync <= pin_meta;
        end
    end

    // Count low time; lows under the reject time never assert reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            low_count <= 16'h0000;
        else if (pin_sync)
            low_count <= 16'h0000;
        else if (low_count != ACCEPT)
            low_count <= low_count + 16'h0001;
    end

    // Count high time while held, so short high spikes do not release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            high_count <= 16'h0000;
        else if (!pin_sync)
            high_count <= 16'h0000;
        else if (high_count != ACCEPT)
            high_count <= high_count + 16'h0001;
    end

    // Filtered reset: set after accept time low, cleared after same time high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reset_seen <= 1'b0;
        else if (!pin_sync && low_count == ACCEPT)
            reset_seen <= 1'b1;
        else if (pin_sync && high_count == ACCEPT)
            reset_seen <= 1'b0;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Release timing is counted from the filtered release, which trails the
    // pin by the filter delay; the phase budgets leave room for that.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state      <= reset_seq_pkg::st_reload;
            timer      <= 32'h0000_0000;
            word_index <= 3'h0;
            was_awake  <= 1'b0;
        end
        else if (take_reset)
        begin
            // Capture sleep state as reset is taken; a reset that arrives
            // during release starts the whole sequence over, so ready never
            // flashes high while the pin is still held low
            state      <= reset_seq_pkg::st_held;
            was_awake  <= !sleep_state;
            timer      <= 32'h0000_0000;
            word_index <= 3'h0;
        end
        else
        begin
            unique case (state)
                reset_seq_pkg::st_run:
                    timer <= 32'h0000_0000;
                reset_seq_pkg::st_held:
                begin
                    // Reload starts at once on release, whatever the sleep state,
                    // so it never waits behind a long blanking sequence
                    if (!reset_seen)
                        state <= reset_seq_pkg::st_reload;
                end
                reset_seq_pkg::st_blank:
                begin
                    // Settings are in place; only the blanking sequence remains
                    if (blank_done)
                        state <= reset_seq_pkg::st_run;
                end
                reset_seq_pkg::st_reload:
                begin
                    // One word per cycle, far inside the reload budget
                    word_index <= word_index + 3'h1;
                    if (word_index == LAST_WORD)
                    begin
                        state <= reset_seq_pkg::st_wait;
                        timer <= 32'h0000_0000;
                    end
                end
                reset_seq_pkg::st_wait:
                begin
                    // Short settle so release completes within reload budget
                    word_index <= 3'h0;
                    if (timer >= 32'(RELOAD_CYCLES / 2))
                    begin
                        // An awake entry stays blank until its sequence ends
                        if (was_awake && !blank_done)
                            state <= reset_seq_pkg::st_blank;
                        else
                            state <= reset_seq_pkg::st_run;
                    end
                    else
                        timer <= timer + 32'h0000_0001;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Blanking sequence timer
    // ------------------------------------------------------------
    // Counted from the moment reset is taken, not from release, so an awake
    // reset is back in run at the blanking maximum after entry, or once reload and settle end if that is later.
    // A long held reset simply lets the count finish while still held.
    assign take_reset = reset_seen && state != reset_seq_pkg::st_held;
    assign blank_done = blank_count >= BLANK_CYCLES - 1;

    // Cleared in run and on every entry; stops once the sequence is done
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            blank_count <= 32'h0000_0000;
        else if (take_reset || state == reset_seq_pkg::st_run)
            blank_count <= 32'h0000_0000;
        else if (was_awake && !blank_done)
            blank_count <= blank_count + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // Settings loaded from storage
    // ------------------------------------------------------------
    // Word 0 carries ID and common voltage; other words are reserved here
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            settings <= '0;
        else if (state == reset_seq_pkg::st_held)
            settings <= '0;
        else if (state == reset_seq_pkg::st_reload && word_index == 3'h1)
            settings <= reset_seq_pkg::settings_t'(nvm_word);
    end

    // Registered outputs
    // All three levels come from one state compare, so they never disagree;
    // the cost is one cycle of lag behind the state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nvm_addr      <= 3'h0;
            in_reset      <= 1'b1;
            display_blank <= 1'b1;
            ready         <= 1'b0;
        end
        else
        begin
            nvm_addr      <= word_index;
            in_reset      <= state != reset_seq_pkg::st_run;
            display_blank <= state != reset_seq_pkg::st_run;
            ready         <= state == reset_seq_pkg::st_run;
        end
    end
endmodule

// File: common/reset_seq_params.svh
// Timing constants and storage word count for the hardware reset sequencer
`ifndef RESET_SEQ_PARAMS_SVH
`define RESET_SEQ_PARAMS_SVH
`define CLK_PERIOD_NS        8
`define SPIKE_REJECT_NS      5000
`define RESET_ACCEPT_NS      9000
`define RELOAD_MAX_MS        5
`define RELEASE_SLEEP_MS     5
`define RELEASE_AWAKE_MS     120
`define BLANK_MAX_MS         120
// Accept a low level after it has lasted beyond the reject time (rounded up)
`define ACCEPT_CYCLES        ((`SPIKE_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOAD_CYCLES        ((`RELOAD_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define BLANK_CYCLES         ((`BLANK_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define NVM_WORDS            8
`endif

// File: common/reset_seq_pkg.sv
// Types shared by the hardware reset sequencer
package reset_seq_pkg;
    typedef enum logic [2:0]
    {
        st_run,
        st_held,
        st_blank,
        st_reload,
        st_wait
    } seq_state_t;

    typedef struct packed
    {
        logic [23:0] id_bytes;
        logic [7:0]  common_voltage_setting;
    } settings_t;
endpackage

// File: test/display_hw_reset_sequencer_sva.sv
// Checker for the hardware reset sequencer ports
`timescale 1ns/1ps
module display_hw_reset_sequencer_sva
#(
    parameter int unsigned RELOAD_CYCLES = 200,
    parameter int unsigned BLANK_CYCLES  = 300
)
(
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic                       hw_reset_n,
    input wire logic                       sleep_state,
    input wire logic [31:0]                nvm_word,
    input wire logic [2:0]                 nvm_addr,
    input wire logic                       in_reset,
    input wire logic                       display_blank,
    input wire logic                       ready,
    input wire reset_seq_pkg::settings_t   settings
);
    localparam int ACC = 625;   // Spike filter span in cycles
    localparam int SLK = 16;    // Margin for sync flops and state steps
    logic [15:0] low_cnt;       // Cycles the pin has been low
    logic [15:0] high_cnt;      // Cycles the pin has been high
    logic        asleep;        // Sleep level when reset was taken
    logic [31:0] w0;            // Stored word at address zero
    logic        long_seen;     // Low run long enough to be taken
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Run lengths saturate so a long idle never wraps back to a match
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            low_cnt <= '0;
            // Pin idles high, so the high run starts saturated
            high_cnt <= '1;
        end
        else
        begin
            low_cnt <= hw_reset_n ? '0 : low_cnt + {15'h0, ~&low_cnt};
            high_cnt <= !hw_reset_n ? '0 : high_cnt + {15'h0, ~&high_cnt};
        end
    // Sleep level latched at reset entry
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            asleep <= 1'b0;
        else if ($rose(in_reset))
            asleep <= sleep_state;
    // Word the settings must come from
    always_ff @(posedge clk)
        if (nvm_addr == 3'h0)
            w0 <= nvm_word;
    // A long low run is remembered until ready returns
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            long_seen <= 1'b0;
        else if (low_cnt >= 16'h0258)
            long_seen <= 1'b1;
        else if ($rose(ready))
            long_seen <= 1'b0;
    chk_spike_reject: assert property (ready && !hw_reset_n && low_cnt < 600 |=> ready)
        else $error("short low pulse dropped ready");
    chk_fall_cause: assert property ($fell(ready) |-> long_seen)
        else $error("ready fell without a long low pulse");
    chk_full_reset: assert property (low_cnt == 1125 |-> in_reset && !ready && settings == '0)
        else $error("long low pulse did not reset");
    chk_blank_pair: assert property (display_blank == in_reset && ready == !in_reset)
        else $error("blank, reset and ready disagree");
    chk_held_glitch: assert property (in_reset && high_cnt < 600 |=> in_reset)
        else $error("short high glitch ended reset");
    chk_reload_value: assert property ($rose(ready) |-> settings == w0)
        else $error("settings not reloaded from storage");
    chk_sleep_release: assert property (asleep && high_cnt == ACC + SLK + RELOAD_CYCLES |-> ready)
        else $error("release from sleep too slow");
    chk_awake_release: assert property (high_cnt == ACC + SLK + BLANK_CYCLES + RELOAD_CYCLES |-> ready)
        else $error("release from awake too slow");
endmodule
bind display_hw_reset_sequencer display_hw_reset_sequencer_sva #(.RELOAD_CYCLES(RELOAD_CYCLES),
    .BLANK_CYCLES(BLANK_CYCLES)) u_sva (.clk(clk), .rstn(rstn), .hw_reset_n(hw_reset_n),
    .sleep_state(sleep_state), .nvm_word(nvm_word), .nvm_addr(nvm_addr), .in_reset(in_reset),
    .display_blank(display_blank), .ready(ready), .settings(settings));

// File: test/host_model.sv
// Host and storage model facing the reset sequencer
`timescale 1ns/1ps
module host_model
(
    input  wire logic        clk,
    input  wire logic [2:0]  nvm_addr,
    output logic             hw_reset_n,
    output logic [31:0]      nvm_word
);
    localparam logic [31:0] WORD0 = 32'h5a3c_c35a; // Arbitrary stored pattern
    // Each address gives a different word, so a wrong index shows
    assign nvm_word = WORD0 ^ {29'h0, nvm_addr};
    initial hw_reset_n = 1'b1;
    // Pin low lo cycles then high hi; returns on the falling edge after the last high cycle
    task automatic drive(input int lo, input int hi);
        @(posedge clk);
        hw_reset_n <= 1'b0;
        repeat (lo) @(posedge clk);
        hw_reset_n <= 1'b1;
        repeat (hi) @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// File: test/display_hw_reset_sequencer_bench.sv
// Self-checking bench for the hardware reset sequencer
`timescale 1ns/1ps
module display_hw_reset_sequencer_bench;
    localparam int RELOAD = 200;  // Shortened reload wait
    localparam int BLANK  = 2000; // Shortened blanking span, outlasts a brief reset
    localparam int BOUND  = 641;  // Filter plus sync margin
    logic clk = 1'b0;
    logic rstn, sleep_state, hw_reset_n, in_reset, display_blank, ready;
    logic [31:0] nvm_word;
    logic [2:0]  nvm_addr;
    reset_seq_pkg::settings_t settings;
    int fails = 0, num_checks = 0, cycles = 0;
    host_model u_host (.clk(clk), .nvm_addr(nvm_addr), .hw_reset_n(hw_reset_n),
        .nvm_word(nvm_word));
    display_hw_reset_sequencer #(.RELOAD_CYCLES(RELOAD), .BLANK_CYCLES(BLANK)) u_dut (.clk(clk),
        .rstn(rstn), .hw_reset_n(hw_reset_n), .sleep_state(sleep_state), .nvm_word(nvm_word),
        .nvm_addr(nvm_addr), .in_reset(in_reset), .display_blank(display_blank), .ready(ready),
        .settings(settings));
    always #4 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cycles until ready, bounded so a stuck design cannot hang
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_spike;
        u_host.drive(500, 40);
        chk("spike ready", ready, 1);
        chk("spike blank", display_blank, 0);
    endtask
    task automatic t_awake;
        int n;
        u_host.drive(1250, 300);
        chk("glitch held", in_reset, 1);
        chk("glitch blank", display_blank, 1);
        chk("glitch cleared", settings, 0);
        u_host.drive(1250, 0);
        wait_ready(n);
        chk("awake release", 32'(n <= BOUND + BLANK + RELOAD), 1);
        chk("awake reload", settings, u_host.WORD0);
    endtask
    // Brief reset while awake: reload lands early, blanking runs on
    task automatic t_brief;
        int n;
        u_host.drive(1250, 800);
        chk("brief reload", settings, u_host.WORD0);
        chk("brief blank", display_blank, 1);
        wait_ready(n);
        chk("brief release", 32'(n <= BOUND + BLANK + RELOAD), 1);
    endtask
    task automatic t_sleep;
        int n;
        @(posedge clk);
        sleep_state <= 1'b1;
        u_host.drive(1250, 0);
        wait_ready(n);
        chk("sleep release", 32'(n <= BOUND + RELOAD), 1);
        chk("sleep reload", settings, u_host.WORD0);
    endtask
    // Cycle ceiling well above the roughly 9000 the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        int n;
        rstn = 1'b0;
        sleep_state = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wait_ready(n);
        chk("boot ready", ready, 1);
        chk("boot reload", settings, u_host.WORD0);
        t_spike();
        t_awake();
        t_brief();
        t_sleep();
        stop_test();
    end
endmodule
